// File: common/mism_pkg.sv
// ============================================================
// register map and field layout
package mism_pkg;
    localparam logic [7:0] MISM_OFS_VOLT_STATUS  = 8'h01;
    localparam logic [7:0] MISM_OFS_THERM_STATUS = 8'h02;
    localparam logic [7:0] MISM_OFS_VOLT_MASK    = 8'h03;
    localparam logic [7:0] MISM_OFS_THERM_MASK   = 8'h04;

    localparam logic [7:0] MISM_RST_VOLT_STATUS  = 8'h00;
    localparam logic [7:0] MISM_RST_THERM_STATUS = 8'h00;
    localparam logic [7:0] MISM_RST_VOLT_MASK    = 8'h00;
    localparam logic [7:0] MISM_RST_THERM_MASK   = 8'h00;
    localparam logic [7:0] MISM_RST_RDATA        = 8'h00;

    // first status register fields
    localparam int MISM_BIT_VOLT_LO   = 0;
    localparam int MISM_NUM_VOLT      = 7;
    localparam int MISM_BIT_ALERT_IN  = 7;

    // second status register fields
    localparam int MISM_BIT_HOT       = 0;
    localparam int MISM_BIT_BOARD     = 1;
    localparam int MISM_BIT_TACH1     = 2;
    localparam int MISM_BIT_TACH2     = 3;
    localparam int MISM_BIT_CHASSIS   = 4;
    localparam int MISM_BIT_OVERTEMP  = 5;

    // second mask register mode fields
    localparam int MISM_BIT_HOT_MODE  = 6;
    localparam int MISM_BIT_OS_MODE   = 7;

    // bits of the second register that take part in status and masking
    localparam logic [7:0] MISM_THERM_LIVE = 8'h3f;
endpackage : mism_pkg

// File: rtl/mism_temp_flag.sv
`timescale 1ns/1ps
// ============================================================
// temperature event generator, default or one-time mode
module mism_temp_flag
    import mism_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic one_time_mode,
    input  wire logic halt,
    input  wire logic conv_done,
    input  wire logic above_limit,
    input  wire logic below_hyst,
    output logic      set_q
);
    logic hot_q;
    logic conv_live;
    logic set_d;

    assign conv_live = conv_done & ~halt;

    // ============================================================
    // hysteresis state: over limit until below hysteresis
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hot_q <= 1'b0;
        end else if (conv_live) begin
            if (above_limit) begin
                hot_q <= 1'b1;
            end else if (below_hyst) begin
                hot_q <= 1'b0;
            end
        end
    end

    // ============================================================
    // event selection
    always_comb begin
        set_d = 1'b0;
        if (conv_live) begin
            if (one_time_mode) begin
                set_d = above_limit & ~hot_q;
            end else begin
                set_d = above_limit | (hot_q & ~below_hyst);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            set_q <= 1'b0;
        end else begin
            set_q <= set_d;
        end
    end
endmodule : mism_temp_flag

// File: rtl/mism_irq.sv
`timescale 1ns/1ps
// What this block does
// - a voltage channel whose reading breaks its high or low limit sets its bit 0..6 of the first status register.
// - a low level on the external alert input sets bit 7 of the first status register.
// - a hot limit violation sets bit 0 of the second status register in the mode chosen by mask 2 bit 6.
// - an alert on the board temperature input sets bit 1 of the second status register.
// - the first and second tach over-limit events set bits 2 and 3 of the second status register.
// - a high chassis intrusion input sets bit 4 of the second status register.
// - an overtemperature limit violation sets bit 5 of the second status register in the mode chosen by mask 2 bit 7.
// - a mask bit at one keeps its status bit from raising the interrupt output.
// - both status and both mask registers are zero after power-on.
// - the interrupt output is driven only while interrupt enable is one.
// - while interrupt clear is one the output is off and monitoring stops, status kept, resuming when it drops.
// - in default temperature mode a read clears the bit and each later conversion sets it until below hysteresis.
// - in one-time temperature mode one event is raised per crossing above the limit after dropping below hysteresis.
module mism_irq
    import mism_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata_q,
    input  wire logic       int_enable,
    input  wire logic       int_clear,
    input  wire logic       conv_done,
    input  wire logic [6:0] voltage_limit_viol,
    input  wire logic       alert_in_n,
    input  wire logic       hot_above_limit,
    input  wire logic       hot_below_hyst,
    input  wire logic       os_above_limit,
    input  wire logic       os_below_hyst,
    input  wire logic       board_temp_alert_input_n,
    input  wire logic       first_tach_over,
    input  wire logic       second_tach_over,
    input  wire logic       chassis_intrusion_input,
    output logic            int_active_q,
    output logic            overtemp_shutdown_flag_q
);
    logic [7:0] volt_status_q;
    logic [7:0] volt_status_d;
    logic [7:0] therm_status_q;
    logic [7:0] therm_status_d;
    logic [7:0] volt_mask_q;
    logic [7:0] therm_mask_q;
    logic [7:0] volt_set;
    logic [7:0] therm_set;
    logic [7:0] volt_clr;
    logic [7:0] therm_clr;
    logic       monitor_on;
    logic       hot_set;
    logic       os_set;
    logic       pending;
    logic       wr_volt_mask;
    logic       wr_therm_mask;
    logic       rd_volt_status;
    logic       rd_therm_status;
    logic [7:0] volt_mask_d;
    logic [7:0] therm_mask_d;
    logic [7:0] rdata_d;
    logic       volt_pending;
    logic       therm_pending;
    logic       int_active_d;
    logic       os_flag_d;
    logic [7:0] therm_pin_set;
    logic [7:0] therm_temp_set;

    // ============================================================
    // helpers
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] clr,
                                         input logic [7:0] set, input logic [7:0] live);
        merge = ((cur & ~clr) | set) & live;
    endfunction : merge

    function automatic logic strobe_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
        strobe_hit = strobe & hit(addr, ofs);
    endfunction : strobe_hit

    function automatic logic any_unmasked(input logic [7:0] status, input logic [7:0] mask,
                                          input logic [7:0] live);
        any_unmasked = |(status & ~mask & live);
    endfunction : any_unmasked

    // ============================================================
    // monitoring gate
    always_comb begin
        monitor_on = ~int_clear;
    end

    // ============================================================
    // register write strobes
    always_comb begin
        wr_volt_mask = strobe_hit(reg_wr, reg_addr, MISM_OFS_VOLT_MASK);
        wr_therm_mask = strobe_hit(reg_wr, reg_addr, MISM_OFS_THERM_MASK);
    end

    // ============================================================
    // register read strobes
    always_comb begin
        rd_volt_status = strobe_hit(reg_rd, reg_addr, MISM_OFS_VOLT_STATUS);
        rd_therm_status = strobe_hit(reg_rd, reg_addr, MISM_OFS_THERM_STATUS);
    end

    // ============================================================
    // temperature sources
    mism_temp_flag u_hot (
        .clk           (clk),
        .arst_n        (arst_n),
        .one_time_mode (therm_mask_q[MISM_BIT_HOT_MODE]),
        .halt          (int_clear),
        .conv_done     (conv_done),
        .above_limit   (hot_above_limit),
        .below_hyst    (hot_below_hyst),
        .set_q         (hot_set)
    );

    mism_temp_flag u_os (
        .clk           (clk),
        .arst_n        (arst_n),
        .one_time_mode (therm_mask_q[MISM_BIT_OS_MODE]),
        .halt          (int_clear),
        .conv_done     (conv_done),
        .above_limit   (os_above_limit),
        .below_hyst    (os_below_hyst),
        .set_q         (os_set)
    );

    // ============================================================
    // voltage and alert event collection
    always_comb begin
        volt_set = 8'h00;
        if (monitor_on) begin
            volt_set[MISM_BIT_VOLT_LO +: MISM_NUM_VOLT] = voltage_limit_viol;
            volt_set[MISM_BIT_ALERT_IN] = ~alert_in_n;
        end
    end

    // ============================================================
    // pin and fan events of the second status register
    always_comb begin
        therm_pin_set = 8'h00;
        if (monitor_on) begin
            therm_pin_set[MISM_BIT_BOARD] = ~board_temp_alert_input_n;
            therm_pin_set[MISM_BIT_TACH1] = first_tach_over;
            therm_pin_set[MISM_BIT_TACH2] = second_tach_over;
            therm_pin_set[MISM_BIT_CHASSIS] = chassis_intrusion_input;
        end
    end

    // ============================================================
    // temperature events of the second status register
    always_comb begin
        therm_temp_set = 8'h00;
        if (monitor_on) begin
            therm_temp_set[MISM_BIT_HOT] = hot_set;
            therm_temp_set[MISM_BIT_OVERTEMP] = os_set;
        end
    end

    // ============================================================
    // second status register events together
    always_comb begin
        therm_set = therm_pin_set | therm_temp_set;
    end

    // ============================================================
    // read clears the voltage status register; a set in the same cycle wins
    always_comb begin
        volt_clr = 8'h00;
        if (rd_volt_status) begin
            volt_clr = 8'hff;
        end
        volt_status_d = merge(volt_status_q, volt_clr, volt_set, 8'hff);
    end

    // ============================================================
    // read clears the thermal status register; a set in the same cycle wins
    always_comb begin
        therm_clr = 8'h00;
        if (rd_therm_status) begin
            therm_clr = 8'hff;
        end
        therm_status_d = merge(therm_status_q, therm_clr, therm_set, MISM_THERM_LIVE);
    end

    // ============================================================
    // voltage status register, host writes have no effect
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            volt_status_q <= MISM_RST_VOLT_STATUS;
        end else begin
            volt_status_q <= volt_status_d;
        end
    end

    // ============================================================
    // thermal status register, host writes have no effect
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            therm_status_q <= MISM_RST_THERM_STATUS;
        end else begin
            therm_status_q <= therm_status_d;
        end
    end

    // ============================================================
    // voltage mask register
    always_comb begin
        volt_mask_d = volt_mask_q;
        if (wr_volt_mask) begin
            volt_mask_d = reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            volt_mask_q <= MISM_RST_VOLT_MASK;
        end else begin
            volt_mask_q <= volt_mask_d;
        end
    end

    // ============================================================
    // thermal mask register, bits 6 and 7 pick the temperature modes
    always_comb begin
        therm_mask_d = therm_mask_q;
        if (wr_therm_mask) begin
            therm_mask_d = reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            therm_mask_q <= MISM_RST_THERM_MASK;
        end else begin
            therm_mask_q <= therm_mask_d;
        end
    end

    // ============================================================
    // read data, unmapped addresses return zero, held between reads
    always_comb begin
        rdata_d = reg_rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                MISM_OFS_VOLT_STATUS:  rdata_d = volt_status_q;
                MISM_OFS_THERM_STATUS: rdata_d = therm_status_q & MISM_THERM_LIVE;
                MISM_OFS_VOLT_MASK:    rdata_d = volt_mask_q;
                MISM_OFS_THERM_MASK:   rdata_d = therm_mask_q;
                default:               rdata_d = MISM_RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_q <= MISM_RST_RDATA;
        end else begin
            reg_rdata_q <= rdata_d;
        end
    end

    // ============================================================
    // unmasked pending sources
    always_comb begin
        volt_pending = any_unmasked(volt_status_q, volt_mask_q, 8'hff);
        therm_pending = any_unmasked(therm_status_q, therm_mask_q, MISM_THERM_LIVE);
        pending = volt_pending | therm_pending;
    end

    // ============================================================
    // interrupt output
    always_comb begin
        int_active_d = pending & int_enable & ~int_clear;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            int_active_q <= 1'b0;
        end else begin
            int_active_q <= int_active_d;
        end
    end

    // ============================================================
    // overtemperature flag, a copy of the status bit
    always_comb begin
        os_flag_d = therm_status_q[MISM_BIT_OVERTEMP];
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overtemp_shutdown_flag_q <= 1'b0;
        end else begin
            overtemp_shutdown_flag_q <= os_flag_d;
        end
    end
endmodule : mism_irq

// File: verification/mism_irq_sva.sv
`timescale 1ns/1ps
// ============================================================
// status and interrupt port checks
module mism_irq_sva (
    input logic       clk,
    input logic       arst_n,
    input logic [7:0] reg_addr,
    input logic       reg_rd,
    input logic [7:0] reg_rdata_q,
    input logic       int_enable,
    input logic       int_clear,
    input logic [6:0] voltage_limit_viol,
    input logic       alert_in_n,
    input logic       board_temp_alert_input_n,
    input logic       first_tach_over,
    input logic       chassis_intrusion_input,
    input logic       int_active_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_enable_gate: assert property (!int_enable |=> !int_active_q) else $error("int without enable");
    a_clear_gate: assert property (int_clear |=> !int_active_q) else $error("int during clear");
    a_unmapped_zero: assert property (reg_rd && (reg_addr == 8'h00 || reg_addr > 8'h04) |=> reg_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (reg_rd && reg_addr == 8'h02 |=> reg_rdata_q[7:6] == 2'b00)
        else $error("reserved bits set");
    a_volt_sticky: assert property ((voltage_limit_viol != 7'h00 && !int_clear) ##1 (reg_rd && reg_addr == 8'h01)
        |=> (reg_rdata_q[6:0] & $past(voltage_limit_viol, 2)) == $past(voltage_limit_viol, 2))
        else $error("voltage bit lost");
    a_alert_sticky: assert property ((!alert_in_n && !int_clear) ##1 (reg_rd && reg_addr == 8'h01)
        |=> reg_rdata_q[7]) else $error("alert bit lost");
    a_board_sticky: assert property ((!board_temp_alert_input_n && !int_clear) ##1 (reg_rd && reg_addr == 8'h02)
        |=> reg_rdata_q[1]) else $error("board bit lost");
    a_tach_sticky: assert property ((first_tach_over && !int_clear) ##1 (reg_rd && reg_addr == 8'h02)
        |=> reg_rdata_q[2]) else $error("tach bit lost");
    a_chassis_sticky: assert property ((chassis_intrusion_input && !int_clear) ##1 (reg_rd && reg_addr == 8'h02)
        |=> reg_rdata_q[4]) else $error("chassis bit lost");
endmodule : mism_irq_sva

// File: verification/mism_host.sv
`timescale 1ns/1ps
// ============================================================
// host side register access, entered and left at a rising edge
module mism_host (
    input  logic       clk,
    input  logic [7:0] reg_rdata_q,
    output logic [7:0] reg_addr,
    output logic       reg_wr,
    output logic [7:0] reg_wdata,
    output logic       reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata_q;
        @(posedge clk);
    endtask : rd
endmodule : mism_host

// File: verification/testbench.sv
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the status and mask block
module testbench
    import mism_pkg::*;
();
    logic        clk = 1'b0, arst_n = 1'b0, int_enable = 1'b0, int_clear = 1'b0, conv = 1'b0;
    logic [11:0] ev = '0;
    logic [1:0]  above = '0, hyst = '0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, d;
    logic        reg_wr, reg_rd, int_q, os_q;
    int          fail_count = 0, n_tests = 0, cycles = 0;
    mism_irq dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .int_enable(int_enable), .int_clear(int_clear),
        .conv_done(conv), .voltage_limit_viol(ev[6:0]), .alert_in_n(~ev[7]), .hot_above_limit(above[0]),
        .hot_below_hyst(hyst[0]), .os_above_limit(above[1]), .os_below_hyst(hyst[1]),
        .board_temp_alert_input_n(~ev[8]), .first_tach_over(ev[9]), .second_tach_over(ev[10]),
        .chassis_intrusion_input(ev[11]), .int_active_q(int_q), .overtemp_shutdown_flag_q(os_q));
    mism_host host (.clk(clk), .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd));
    initial forever #5 clk = ~clk;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        host.rd(a, d);
        chk(what, exp, d);
    endtask : rdchk
    task automatic pulse(input logic [11:0] v);
        ev <= v;
        @(posedge clk);
        ev <= '0;
    endtask : pulse
    task automatic conv_pulse();
        conv <= 1'b1;
        @(posedge clk);
        conv <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : conv_pulse
    task automatic int_chk(input logic exp, input string what);
        repeat (2) @(posedge clk);
        #1 chk(what, {7'h00, exp}, {7'h00, int_q});
        @(posedge clk);
    endtask : int_chk
    // second status expectation from the event vector
    function automatic logic [7:0] exp2(input logic [11:0] v);
        return {3'b000, v[11:8], 1'b0};
    endfunction : exp2
    initial begin
        void'($urandom(62905));
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        for (int a = 1; a <= 5; a++) rdchk(a[7:0], 8'h00, "reset value");
        host.wr(MISM_OFS_VOLT_STATUS, 8'hff);
        host.wr(MISM_OFS_THERM_STATUS, 8'hff);
        rdchk(MISM_OFS_VOLT_STATUS, 8'h00, "status1 write");
        rdchk(MISM_OFS_THERM_STATUS, 8'h00, "status2 write");
        repeat (4) begin
            logic [7:0] m;
            m = 8'($urandom);
            host.wr(MISM_OFS_VOLT_MASK, m);
            host.wr(MISM_OFS_THERM_MASK, ~m);
            rdchk(MISM_OFS_VOLT_MASK, m, "mask1");
            rdchk(MISM_OFS_THERM_MASK, ~m, "mask2");
        end
        host.wr(MISM_OFS_THERM_MASK, 8'h00);
        host.wr(MISM_OFS_VOLT_MASK, 8'h00);
        pulse(12'hf00);
        rdchk(MISM_OFS_THERM_STATUS, 8'h1e, "status2 corner");
        for (int i = 0; i < 8; i++) begin
            logic [11:0] v;
            v = (i == 0) ? 12'h0ff : 12'($urandom);
            pulse(v);
            rdchk(MISM_OFS_VOLT_STATUS, v[7:0], "status1");
            rdchk(MISM_OFS_THERM_STATUS, exp2(v), "status2");
            rdchk(MISM_OFS_VOLT_STATUS, 8'h00, "status1 cleared");
        end
        for (int k = 0; k < 2; k++) begin
            above[k] <= 1'b1;
            conv_pulse();
            #1 chk("os flag", k ? 8'h01 : 8'h00, {7'h00, os_q});
            @(posedge clk);
            rdchk(MISM_OFS_THERM_STATUS, k ? 8'h20 : 8'h01, "temp default");
            conv_pulse();
            rdchk(MISM_OFS_THERM_STATUS, k ? 8'h20 : 8'h01, "temp repeat");
            above[k] <= 1'b0;
            conv_pulse();
            rdchk(MISM_OFS_THERM_STATUS, k ? 8'h20 : 8'h01, "temp above hyst");
            hyst[k] <= 1'b1;
            conv_pulse();
            rdchk(MISM_OFS_THERM_STATUS, 8'h00, "temp below");
            host.wr(MISM_OFS_THERM_MASK, k ? 8'h80 : 8'h40);
            hyst[k] <= 1'b0;
            above[k] <= 1'b1;
            conv_pulse();
            rdchk(MISM_OFS_THERM_STATUS, k ? 8'h20 : 8'h01, "one time");
            conv_pulse();
            rdchk(MISM_OFS_THERM_STATUS, 8'h00, "one time repeat");
            above[k] <= 1'b0;
            hyst[k] <= 1'b1;
            conv_pulse();
            hyst[k] <= 1'b0;
            above[k] <= 1'b1;
            conv_pulse();
            rdchk(MISM_OFS_THERM_STATUS, k ? 8'h20 : 8'h01, "one time rearm");
            above[k] <= 1'b0;
            hyst[k] <= 1'b1;
            conv_pulse();
            host.wr(MISM_OFS_THERM_MASK, 8'h00);
        end
        int_enable <= 1'b1;
        pulse(12'h200);
        int_chk(1'b1, "int raised");
        rdchk(MISM_OFS_THERM_STATUS, 8'h04, "tach");
        host.wr(MISM_OFS_THERM_MASK, 8'h04);
        pulse(12'h200);
        int_chk(1'b0, "int masked");
        rdchk(MISM_OFS_THERM_STATUS, 8'h04, "masked status");
        host.wr(MISM_OFS_THERM_MASK, 8'h00);
        int_enable <= 1'b0;
        pulse(12'h200);
        int_chk(1'b0, "int disabled");
        int_enable <= 1'b1;
        int_chk(1'b1, "int enabled");
        int_clear <= 1'b1;
        int_chk(1'b0, "int cleared");
        pulse(12'h800);
        int_clear <= 1'b0;
        rdchk(MISM_OFS_THERM_STATUS, 8'h04, "halted status");
        finish_test();
    end
endmodule : testbench
bind mism_irq mism_irq_sva u_sva (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .int_enable(int_enable), .int_clear(int_clear),
    .voltage_limit_viol(voltage_limit_viol), .alert_in_n(alert_in_n),
    .board_temp_alert_input_n(board_temp_alert_input_n), .first_tach_over(first_tach_over),
    .chassis_intrusion_input(chassis_intrusion_input), .int_active_q(int_active_q));
